// File: hdl/boolean_output_and_fast_pwm.sv
// Purpose: logic outputs, delays, input functions, enables and fast pwm pairs
// Assumes: rail flags come from same-clock sequencer logic; pins are asynchronous
// Notes: pwm divides sys_clk ticks standing in for the fast source
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "bool_out_map.svh"

module boolean_output_and_fast_pwm import bool_out_pkg::*; #(
  parameter int DIV_W = 14,
  parameter logic [7:0] FAST_MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] gpi_pin,
  input wire logic bus_control_input,
  input wire rail_in_type rail_in,
  input wire logic seq_off,
  output logic [7:0] gpo_out,
  output logic [7:0] gpo_oe_n,
  output logic power_good_out,
  output logic [11:0] rail_margin,
  output func_out_type func_out
);

  // ****************************************
  // checks and helpers
  // ****************************************
  if (DIV_W < 2 || DIV_W > 14) begin : g_chk
    $error("DIV_W must lie in 2..14");
  end

  function automatic logic [31:0] be_merge(logic [31:0] o, logic [31:0] w, logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic spec_act(logic [3:0] f, logic [7:0] ins);
    return f[3] & ins[f[2:0]];
  endfunction

  function automatic logic term_eval(logic [31:0] t, logic [7:0] outs, logic [7:0] ins,
                                     logic [11:0] rails);
    return t[`TERM_EN] & (&(~t[7:0] | outs)) & (&(~t[15:8] | ins)) & (&(~t[27:16] | rails));
  endfunction

  function automatic logic [2:0] first3(logic [7:0] def, logic [7:0] act);
    logic [2:0] r;
    int n;
    r = 3'h0;
    n = 0;
    for (int k = 0; k < 8; k++) begin
      if (def[k] && n < 3) begin
        r[n] = act[k];
        n++;
      end
    end
    return r;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // cleared pins read active under the reset polarity until software sets it
  logic [7:0] gpi_s1_q, gpi_s2_q;
  logic bc_s1_q, bc_s2_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpi_s1_q <= 8'h00;
      gpi_s2_q <= 8'h00;
      bc_s1_q <= 1'b0;
      bc_s2_q <= 1'b0;
    end else begin
      gpi_s1_q <= gpi_pin;
      gpi_s2_q <= gpi_s1_q;
      bc_s1_q <= bus_control_input;
      bc_s2_q <= bc_s1_q;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic clr_q;
  logic [15:0] incfg_q;
  logic [19:0] spec_q;
  logic [23:0] pgcfg_q;
  logic [DIV_W-1:0] div_q [4];
  logic [DIV_W+3:0] duty_q [8];
  logic [31:0] term0_q [8];
  logic [31:0] term1_q [8];
  logic [31:0] cfg_q [8];
  logic [7:0] lo_q;
  logic [11:0] lat_q;
  logic [31:0] rd_d;
  logic wr_go;
  logic [2:0] grp, idx;
  logic [7:0] in_act;

  // writes to unmapped entries are dropped without an error
  assign grp = avs_address[7:5];
  assign idx = avs_address[4:2];
  // writes land at the edge where the master sees waitrequest low
  assign wr_go = avs_write & ~avs_waitrequest;
  assign in_act = gpi_s2_q ~^ incfg_q[7:0];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_q <= 1'b0;
      incfg_q <= 16'hff00;
      spec_q <= 20'h00000;
      pgcfg_q <= 24'h000000;
      for (int k = 0; k < 4; k++) begin
        div_q[k] <= DIV_W'(`MIN_DIV);
      end
      for (int k = 0; k < 8; k++) begin
        duty_q[k] <= '0;
        term0_q[k] <= `RST_WORD;
        term1_q[k] <= `RST_WORD;
        cfg_q[k] <= `RST_WORD;
      end
    end else begin
      clr_q <= wr_go && grp == `GRP_MISC && idx == `IDX_CTRL && avs_byteenable[0]
               && avs_writedata[`CTRL_CLR];
      if (wr_go) begin
        unique case (grp)
          `GRP_MISC: begin
            if (idx == `IDX_INCFG) incfg_q <= 16'(be_merge(32'(incfg_q), avs_writedata, avs_byteenable));
            if (idx == `IDX_SPEC) spec_q <= 20'(be_merge(32'(spec_q), avs_writedata, avs_byteenable));
            if (idx == `IDX_PGCFG) pgcfg_q <= 24'(be_merge(32'(pgcfg_q), avs_writedata, avs_byteenable));
          end
          `GRP_DIV: begin
            if (idx < 3'h4) begin
              div_q[idx[1:0]] <= DIV_W'(be_merge(32'(div_q[idx[1:0]]), avs_writedata, avs_byteenable));
            end
          end
          `GRP_DUTY: duty_q[idx] <= (DIV_W+4)'(be_merge(32'(duty_q[idx]), avs_writedata, avs_byteenable));
          `GRP_TERM0: term0_q[idx] <= be_merge(term0_q[idx], avs_writedata, avs_byteenable);
          `GRP_TERM1: term1_q[idx] <= be_merge(term1_q[idx], avs_writedata, avs_byteenable);
          `GRP_CFG: cfg_q[idx] <= be_merge(cfg_q[idx], avs_writedata, avs_byteenable);
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    rd_d = 32'h0;
    unique case (grp)
      `GRP_MISC: begin
        if (idx == `IDX_INCFG) rd_d = 32'(incfg_q);
        if (idx == `IDX_SPEC) rd_d = 32'(spec_q);
        if (idx == `IDX_PGCFG) rd_d = 32'(pgcfg_q);
        if (idx == `IDX_STAT) rd_d = {1'b0, func_out.fault, power_good_out, bc_s2_q, lat_q, lo_q, in_act};
      end
      `GRP_DIV: rd_d = (idx < 3'h4) ? 32'(div_q[idx[1:0]]) : 32'h0;
      `GRP_DUTY: rd_d = 32'(duty_q[idx]);
      `GRP_TERM0: rd_d = term0_q[idx];
      `GRP_TERM1: rd_d = term1_q[idx];
      `GRP_CFG: rd_d = cfg_q[idx];
      default: rd_d = 32'h0;
    endcase
  end

  // one wait cycle, then one answer cycle, then idle again
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_d;
      end
    end
  end

  // ****************************************
  // latched rail flags and input functions
  // ****************************************
  // clear acts on a level, so a held clear input empties the flags every cycle
  // set wins over clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_q <= 12'h000;
    end else begin
      lat_q <= (lat_q & ~{12{clr_q | spec_act(spec_q[7:4], in_act)}}) | rail_in.fault;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      func_out <= '0;
      rail_margin <= 12'h000;
      power_good_out <= 1'b0;
    end else begin
      // each spec field picks one pin by encoding; sel_state takes the first three pins of its incfg mask
      func_out.fault <= spec_q[3] & ~in_act[spec_q[2:0]];
      rail_margin <= spec_act(spec_q[11:8], in_act) ? pgcfg_q[23:12] : 12'h000;
      func_out.margin_low <= spec_act(spec_q[11:8], in_act) & spec_act(spec_q[15:12], in_act);
      func_out.fan_en <= spec_act(spec_q[19:16], in_act);
      func_out.start_ok <= bc_s2_q;
      func_out.sel_state <= first3(incfg_q[15:8], in_act);
      power_good_out <= (pgcfg_q[11:0] != 12'h000) & (&(rail_in.pg | ~pgcfg_q[11:0])) & ~seq_off;
    end
  end

  // ****************************************
  // fast pwm pairs
  // ****************************************
  logic [DIV_W-1:0] pcnt_q [4];

  for (genvar p = 0; p < 4; p++) begin : g_pair
    logic [DIV_W-1:0] eff;
    // a divider below two would stall the pair, so it is clamped
    // divide by at least two
    assign eff = (div_q[p] < DIV_W'(`MIN_DIV)) ? DIV_W'(`MIN_DIV) : div_q[p];
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        pcnt_q[p] <= '0;
      end else begin
        pcnt_q[p] <= (pcnt_q[p] >= eff - DIV_W'(1)) ? '0 : pcnt_q[p] + DIV_W'(1);
      end
    end
  end

  // ****************************************
  // per output logic, delay and pin drive
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_out
    logic [11:0] rs0, rs1;
    logic t0, t1, res, use_d, fp, drv, v;
    logic [15:0] cnt_q;
    logic tgt_q;
    dly_type st_q;
    src_type src, psrc;
    logic [3:0] ridx;

    assign rs0 = term0_q[i][29:28] == 2'h0 ? rail_in.pg : term0_q[i][29:28] == 2'h1 ? rail_in.fault :
                 term0_q[i][29:28] == 2'h2 ? rail_in.warn : lat_q;
    assign rs1 = term1_q[i][29:28] == 2'h0 ? rail_in.pg : term1_q[i][29:28] == 2'h1 ? rail_in.fault :
                 term1_q[i][29:28] == 2'h2 ? rail_in.warn : lat_q;
    assign t0 = term_eval(term0_q[i], lo_q, in_act, rs0);
    assign t1 = term_eval(term1_q[i], lo_q, in_act, rs1);
    // the delayed output picks the path, so a delay also holds the choice
    // one path or both ORed
    assign res = cfg_q[i][`CFG_SM] ? (lo_q[i] ? t0 : t1) : (t0 | t1);
    assign use_d = (res ? cfg_q[i][`CFG_DLY_AS] : cfg_q[i][`CFG_DLY_DE]) && cfg_q[i][31:16] != 16'h0;

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        st_q <= DLY_IDLE;
        lo_q[i] <= 1'b0;
        tgt_q <= 1'b0;
        cnt_q <= 16'h0;
      end else begin
        unique case (st_q)
          DLY_IDLE: begin
            if (res != lo_q[i]) begin
              if (use_d) begin
                st_q <= DLY_WAIT;
                tgt_q <= res;
                cnt_q <= 16'h1;
              end else begin
                lo_q[i] <= res;
              end
            end
          end
          DLY_WAIT: begin
            if (!cfg_q[i][`CFG_IGN] && res != tgt_q) begin
              st_q <= DLY_IDLE;
            end else if (cnt_q >= cfg_q[i][31:16]) begin
              lo_q[i] <= tgt_q;
              st_q <= DLY_IDLE;
            end else begin
              cnt_q <= cnt_q + 16'h1;
            end
          end
        endcase
      end
    end

    // zero duty keeps the pin low; a large duty holds it high
    // duty in sixteenths of a tick
    assign fp = duty_q[i] > {pcnt_q[i/2], 4'h0};
    assign src = src_type'(cfg_q[i][2:0]);
    assign psrc = src_type'(cfg_q[i^1][2:0]);
    assign ridx = cfg_q[i][13:10];

    always_comb begin
      drv = FAST_MASK[i];
      v = 1'b0;
      unique case (src)
        SRC_NONE: begin
          if (psrc == SRC_FAST && FAST_MASK[i]) begin
            v = fp;
          end
        end
        SRC_DIRECT: v = cfg_q[i][`CFG_DVAL] ^ cfg_q[i][`CFG_INV];
        SRC_LOGIC: v = lo_q[i] ^ cfg_q[i][`CFG_INV];
        SRC_RAIL: v = (ridx < 4'd12 ? rail_in.en_req[ridx] : 1'b0) ^ cfg_q[i][`CFG_INV];
        SRC_FAST: v = FAST_MASK[i] & fp;
        default: v = 1'b0;
      endcase
      if (src == SRC_DIRECT || src == SRC_LOGIC || src == SRC_RAIL) begin
        drv = ~(cfg_q[i][`CFG_OD] & v);
      end
    end

    // reset: fast pins low, others released
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        gpo_out[i] <= 1'b0;
        gpo_oe_n[i] <= ~FAST_MASK[i];
      end else begin
        gpo_out[i] <= drv & v;
        gpo_oe_n[i] <= ~drv;
      end
    end
  end

endmodule // boolean_output_and_fast_pwm

// File: hdl/bool_out_map.svh
// Purpose: register offsets and field positions of the boolean output block
// Assumes: byte addresses on an 8-bit avalon address, one 32-bit word each
// Notes: address bits [7:5] pick a group, bits [4:2] the entry in it
`ifndef BOOL_OUT_MAP_SVH
`define BOOL_OUT_MAP_SVH

// ****************************************
// address groups and misc entries
// ****************************************
`define GRP_MISC 3'h0
`define GRP_DIV 3'h1
`define GRP_DUTY 3'h2
`define GRP_TERM0 3'h4
`define GRP_TERM1 3'h5
`define GRP_CFG 3'h6
`define IDX_CTRL 3'h0
`define IDX_INCFG 3'h1
`define IDX_SPEC 3'h2
`define IDX_STAT 3'h3
`define IDX_PGCFG 3'h4

// ****************************************
// field positions
// ****************************************
`define CTRL_CLR 0
`define CFG_DVAL 3
`define CFG_DLY_AS 4
`define CFG_DLY_DE 5
`define CFG_IGN 6
`define CFG_SM 7
`define CFG_INV 8
`define CFG_OD 9
`define TERM_EN 30
`define RAILS 12
`define MIN_DIV 2
`define RST_WORD 32'h0000_0000

`endif

// File: hdl/bool_out_pkg.sv
// Purpose: types shared by the boolean output block and its bench
// Assumes: twelve rails, eight logic outputs
// Notes: constants live in bool_out_map.svh
package bool_out_pkg;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_DIRECT = 3'b001,
    SRC_LOGIC = 3'b010,
    SRC_RAIL = 3'b011,
    SRC_FAST = 3'b100
  } src_type;

  typedef enum logic {DLY_IDLE = 1'b0, DLY_WAIT = 1'b1} dly_type;

  typedef struct packed {
    logic [11:0] en_req;
    logic [11:0] warn;
    logic [11:0] fault;
    logic [11:0] pg;
  } rail_in_type;

  typedef struct packed {
    logic fault;
    logic margin_low;
    logic fan_en;
    logic start_ok;
    logic [2:0] sel_state;
  } func_out_type;
endpackage

// File: tb/bool_out_checker.sv
// Purpose: port-level checks for the logic output block
// Assumes: one clock domain, asynchronous low reset
// Notes: watches design ports only, inputs and outputs
`timescale 1ns/1ns
module bool_out_checker import bool_out_pkg::*; #(
  parameter int DIV_W = 14,
  parameter logic [7:0] FAST_MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] gpi_pin,
  input wire logic bus_control_input,
  input wire rail_in_type rail_in,
  input wire logic seq_off,
  input wire logic [7:0] gpo_out,
  input wire logic [7:0] gpo_oe_n,
  input wire logic power_good_out,
  input wire logic [11:0] rail_margin,
  input wire func_out_type func_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wait_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer missing");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
  wait_idle_a: assert property (
    !avs_read && !avs_write |=> avs_waitrequest) else $error("answer without request");
  unmapped_zero_a: assert property (
    avs_read && avs_waitrequest && avs_address[7:4] == 4'h3 |=> avs_readdata == 32'h0) else $error("unmapped read");
  readdata_hold_a: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("read data moved");
  pg_off_a: assert property (
    seq_off |=> !power_good_out) else $error("power good during off");
  // released reset must still show the reset pin state
  reset_pins_a: assert property (
    $rose(rst_b) |-> gpo_out == 8'h00 && gpo_oe_n == ~FAST_MASK && avs_waitrequest) else $error("reset pins");
  direct_high_a: assert property (
    avs_write && !avs_waitrequest && avs_address == 8'hc0 && avs_writedata == 32'h9
    |-> ##[1:4] gpo_out[0] && !gpo_oe_n[0]) else $error("direct high missing");
  direct_low_a: assert property (
    avs_write && !avs_waitrequest && avs_address == 8'hc0 && avs_writedata == 32'h1
    |-> ##[1:4] !gpo_out[0] && !gpo_oe_n[0]) else $error("direct low missing");
endmodule // bool_out_checker

// File: tb/rail_bank.sv
// Purpose: supplies and a cascade master facing the block
// Assumes: a rail reports good a fixed ramp after its enable
// Notes: warnings stay quiet; faults follow the bench
`timescale 1ns/1ns
module rail_bank import bool_out_pkg::*; #(
  parameter int RAMP = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] rail_on,
  input wire logic master_on,
  input wire logic [11:0] rail_bad,
  output rail_in_type rail_in,
  output logic master_pg
);
  logic [11:0] pg_q [RAMP];
  logic [3:0] up_q;
  // good drops at once when the enable goes, so no stale good
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_q <= '{default: '0};
    end else begin
      pg_q[0] <= rail_on;
      for (int i = 1; i < RAMP; i++) pg_q[i] <= pg_q[i-1] & rail_on;
    end
  end
  assign rail_in = '{en_req: rail_on, warn: 12'h000, fault: rail_bad, pg: pg_q[RAMP-1] & rail_on};
  // master good eight cycles after its enable, off at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 4'h0;
    else if (!master_on) up_q <= 4'h0;
    else if (up_q != 4'h8) up_q <= up_q + 4'h1;
  end
  assign master_pg = master_on && up_q == 4'h8;
endmodule // rail_bank

// File: tb/test_boolean_output_and_fast_pwm.sv
// Purpose: self-checking bench for the logic output block
// Assumes: registers at the offsets of the map header
// Notes: pin waits cover the two-flop input sync
`timescale 1ns/1ns
module test_boolean_output_and_fast_pwm import bool_out_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] gpi_pin = 8'h80;
  logic bus_control_input;
  rail_in_type rail_in;
  logic seq_off = 1'b0;
  logic [7:0] gpo_out;
  logic [7:0] gpo_oe_n;
  logic power_good_out;
  logic [11:0] rail_margin;
  func_out_type func_out;
  logic [11:0] rail_on = 12'h000;
  logic [11:0] rail_bad = 12'h000;
  logic master_on = 1'b0;
  logic [31:0] rd;
  logic p;
  int failures = 0;
  int n_compared = 0;
  int hi, rises, part;
  logic [39:0] cfg [15] = '{40'h04_0000_ffff, 40'h08_000c_ed0f, 40'h10_0000_5003, 40'h84_4000_0300,
    40'ha4_4000_0400, 40'hc4_0000_0002, 40'h98_4000_0100, 40'hb8_4000_0200, 40'hd8_0000_0082,
    40'h88_4000_0800, 40'hc8_0008_0032, 40'h8c_4003_0000, 40'hcc_0000_0002, 40'h9c_7001_0000,
    40'hdc_0000_0002};
  // gpi, then {out6}, {out1, fan, fault, margin low}, margined rails
  logic [27:0] rows [6] = '{28'h80_00_000, 28'h83_18_000, 28'h94_0c_000, 28'ha1_00_005, 28'he3_19_005,
    28'h00_02_000};
  boolean_output_and_fast_pwm DUT (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpi_pin(gpi_pin),
    .bus_control_input(bus_control_input), .rail_in(rail_in), .seq_off(seq_off), .gpo_out(gpo_out),
    .gpo_oe_n(gpo_oe_n), .power_good_out(power_good_out), .rail_margin(rail_margin), .func_out(func_out));
  rail_bank far (.sys_clk(sys_clk), .rst_b(rst_b), .rail_on(rail_on), .master_on(master_on), .rail_in(rail_in),
    .master_pg(bus_control_input), .rail_bad(rail_bad));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pulse(input int w);
    gpi_pin <= 8'h88;
    tick(w);
    gpi_pin <= 8'h80;
    hi = 0;
    repeat (40) begin
      @(posedge sys_clk);
      hi += (gpo_out[2] === 1'b1);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(4);
    chk({gpo_out, gpo_oe_n, 7'h0, avs_waitrequest}, {8'h00, ~8'hff, 8'h01});
    rst_b <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_ff00);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
    foreach (rows[i]) begin
      gpi_pin <= rows[i][27:20];
      tick(8);
      chk({3'h0, gpo_out[6], gpo_out[1], func_out.fan_en, func_out.fault, func_out.margin_low, rail_margin},
        rows[i][19:0]);
    end
    $display("end table");
    bus(1'b1, 8'h04, 32'h0000_f2ee);
    tick(4);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd[7:0], 8'h11);
    chk(func_out.sel_state, 3'b010);
    bus(1'b1, 8'h04, 32'h0000_ffff);
    gpi_pin <= 8'h80;
    tick(8);
    pulse(3);
    chk(hi, 0);
    bus(1'b1, 8'hc8, 32'h0008_0072);
    pulse(3);
    chk(hi >= 8 && hi < 40, 1);
    $display("end delays");
    bus(1'b1, 8'h28, 32'h4);
    bus(1'b1, 8'h50, 32'h20);
    bus(1'b1, 8'h54, 32'h10);
    bus(1'b1, 8'hd0, 32'h4);
    tick(8);
    {hi, rises, part} = '0;
    p = gpo_out[4];
    repeat (40) begin
      @(posedge sys_clk);
      rises += (gpo_out[4] === 1'b1 && p === 1'b0);
      hi += (gpo_out[4] === 1'b1);
      part += (gpo_out[5] === 1'b1);
      p = gpo_out[4];
    end
    chk(rises, 10);
    chk(hi, 20);
    chk(part, 10);
    $display("end pwm");
    rail_on <= 12'h003;
    tick(10);
    chk({gpo_out[3], power_good_out}, 2'b11);
    rail_on <= 12'h001;
    tick(10);
    chk({gpo_out[3], power_good_out}, 2'b00);
    chk(func_out.start_ok, 1'b0);
    rail_on <= 12'h003;
    seq_off <= 1'b1;
    master_on <= 1'b1;
    tick(16);
    chk(power_good_out, 1'b0);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd[28], 1'b1);
    chk(func_out.start_ok, 1'b1);
    rail_bad <= 12'h001;
    tick(1);
    rail_bad <= 12'h000;
    tick(8);
    chk(gpo_out[7], 1'b1);
    bus(1'b1, 8'h00, 32'h1);
    tick(4);
    chk(gpo_out[7], 1'b0);
    $display("end rails");
    bus(1'b1, 8'hc0, 32'h9);
    tick(4);
    chk({gpo_out[0], gpo_oe_n[0]}, 2'b10);
    bus(1'b1, 8'hc0, 32'h1);
    tick(4);
    chk({gpo_out[0], gpo_oe_n[0]}, 2'b00);
    bus(1'b1, 8'hc0, 32'h209);
    tick(4);
    chk(gpo_oe_n[0], 1'b1);
    $display("end direct");
    rst_b <= 1'b0;
    tick(2);
    chk({gpo_out, gpo_oe_n, 7'h0, avs_waitrequest}, {8'h00, ~8'hff, 8'h01});
    rst_b <= 1'b1;
    tick(4);
    chk(gpo_out, 8'h00);
    $display("end reset");
    test_done();
  end
  // whole run is well under a thousand cycles
  initial begin
    #500_000;
    failures++;
    test_done();
  end
endmodule // test_boolean_output_and_fast_pwm
bind boolean_output_and_fast_pwm bool_out_checker #(.DIV_W(DIV_W), .FAST_MASK(FAST_MASK)) chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .gpi_pin(gpi_pin), .bus_control_input(bus_control_input),
  .rail_in(rail_in), .seq_off(seq_off), .gpo_out(gpo_out), .gpo_oe_n(gpo_oe_n),
  .power_good_out(power_good_out), .rail_margin(rail_margin), .func_out(func_out));
